// File: src/lvrx_pkg.sv
// constants and types for the lvds receive word alignment block
// Summary of operation
// - rising-edge option captures serial data on rising link clock, else falling
// - deselecting rising-edge option moves the capture phase by half a cycle
// - edge selection exists only without phase alignment and with hard serdes
// - asserted receiver reset clears all receiver logic asynchronously, not the pll
// - the receiver reset input is honoured only in the logic-element build
// - each slip pulse shifts that channel's word boundary by exactly one bit
// - no upper limit on slip high or low time; each level must span a parallel tick to be seen
// - realigned valid words appear on third parallel cycle after a slip edge
// - per-channel slip gives every channel its own slip input
// - falling-centred data on a shared pll uses falling capture, same settings
// - alignment reset clears alignment logic and zeroes the slip latency count
// - rollover output rises when the slip latency count hits its rollover point
// - rollover point is configurable from 1 to 11, default the word width
// - with output registering on, words are registered on the parallel tick
package lvrx_pkg;
    localparam int CH = 4;
    localparam int DESER = 8;
    localparam int CNT_W = 4;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h10;

    // ctrl fields
    localparam int CTRL_RISE_BIT = 0;
    localparam int CTRL_ACLR_BIT = 1;
    localparam int CTRL_ROLL_LSB = 8;
    // status fields
    localparam int STAT_VALID_LSB = 0;
    localparam int STAT_MAX_LSB = 8;

    // reset values and limits
    localparam logic CTRL_RISE_RST = 1'b1;
    localparam logic [CNT_W-1:0] ROLL_MIN = 4'h1;
    localparam logic [CNT_W-1:0] ROLL_MAX = 4'hb;
    localparam logic [CNT_W-1:0] ROLL_RST = 4'h8;
    // valid words resume on the third parallel tick after a slip edge
    localparam logic [1:0] VALID_WAIT = 2'h2;
endpackage : lvrx_pkg

// File: src/lvrx_reg_if.sv
// configuration and status carrier between register slave and core
`timescale 1ns/10ps
interface lvrx_reg_if;
    logic edge_rise_sel;
    logic align_clr;
    logic [lvrx_pkg::CNT_W-1:0] roll_limit;
    logic [lvrx_pkg::CH-1:0] valid;
    logic [lvrx_pkg::CH-1:0] max;
    logic [lvrx_pkg::DESER-1:0] word [lvrx_pkg::CH];

    modport regs (
        output edge_rise_sel,
        output align_clr,
        output roll_limit,
        input valid,
        input max,
        input word
    );
    modport core (
        input edge_rise_sel,
        input align_clr,
        input roll_limit,
        output valid,
        output max,
        output word
    );
endinterface : lvrx_reg_if

// File: src/lvrx_slip.sv
// per-channel slip edge detect, latency counter and valid blanking
`timescale 1ns/10ps
module lvrx_slip (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic slip_in,
    input wire logic align_clr,
    input wire logic [lvrx_pkg::CNT_W-1:0] roll_limit,
    output logic slip_req,
    output logic blank,
    output logic at_max
);
    logic slip_prev;
    logic [lvrx_pkg::CNT_W-1:0] lat_cnt;
    logic [1:0] wait_cnt;
    logic slip_rise;
    logic wrap;
    logic [lvrx_pkg::CNT_W-1:0] lat_inc;

    // only the edge counts, so a long high level slips once
    assign slip_rise = tick & slip_in & ~slip_prev;
    assign lat_inc = lat_cnt + 4'h1;
    assign wrap = (lat_inc >= roll_limit);
    assign slip_req = slip_rise & ~align_clr;
    assign blank = slip_rise | (wait_cnt != 2'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_prev <= 1'b0;
        end else if (tick) begin
            slip_prev <= slip_in;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_cnt <= 4'h0;
            at_max <= 1'b0;
        end else if (align_clr) begin
            lat_cnt <= 4'h0;
            at_max <= 1'b0;
        end else if (slip_req) begin
            lat_cnt <= wrap ? 4'h0 : lat_inc;
            at_max <= wrap;
        end else if (tick) begin
            at_max <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 2'h0;
        end else if (slip_rise) begin
            wait_cnt <= lvrx_pkg::VALID_WAIT;
        end else if (tick && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule : lvrx_slip

// File: src/lvrx_apb.sv
// apb register slave for control, status and captured words
`timescale 1ns/10ps
module lvrx_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [lvrx_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lvrx_reg_if.regs cfg
);
    logic rise_sel;
    logic aclr;
    logic [lvrx_pkg::CNT_W-1:0] roll;
    logic setup;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_data;
    logic [1:0] data_idx;
    logic [31:0] rd_word;
    logic [lvrx_pkg::CNT_W-1:0] wr_roll;
    logic [lvrx_pkg::CNT_W-1:0] roll_clamp;

    assign setup = psel & ~penable;
    assign hit_ctrl = (paddr == lvrx_pkg::CTRL_OFS);
    assign hit_stat = (paddr == lvrx_pkg::STAT_OFS);
    assign hit_data = (paddr[7:4] == lvrx_pkg::DATA_OFS[7:4])
        & (paddr[1:0] == 2'h0);
    assign data_idx = paddr[3:2];
    assign wr_roll = pwdata[lvrx_pkg::CTRL_ROLL_LSB +: lvrx_pkg::CNT_W];
    // out-of-range rollover points are pulled into 1..11
    assign roll_clamp = (wr_roll < lvrx_pkg::ROLL_MIN) ? lvrx_pkg::ROLL_MIN :
        (wr_roll > lvrx_pkg::ROLL_MAX) ? lvrx_pkg::ROLL_MAX : wr_roll;

    always_comb begin
        rd_word = 32'h0;
        if (hit_ctrl) begin
            rd_word[lvrx_pkg::CTRL_RISE_BIT] = rise_sel;
            rd_word[lvrx_pkg::CTRL_ACLR_BIT] = aclr;
            rd_word[lvrx_pkg::CTRL_ROLL_LSB +: lvrx_pkg::CNT_W] = roll;
        end else if (hit_stat) begin
            rd_word[lvrx_pkg::STAT_VALID_LSB +: lvrx_pkg::CH] = cfg.valid;
            rd_word[lvrx_pkg::STAT_MAX_LSB +: lvrx_pkg::CH] = cfg.max;
        end else if (hit_data) begin
            rd_word[lvrx_pkg::DESER-1:0] = cfg.word[data_idx];
        end
    end

    // zero-wait answer: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~(hit_ctrl
                | ((hit_stat | hit_data) & ~pwrite));
            prdata <= (setup && !pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_sel <= lvrx_pkg::CTRL_RISE_RST;
            aclr <= 1'b0;
            roll <= lvrx_pkg::ROLL_RST;
        end else if (psel && penable && pready && pwrite && hit_ctrl) begin
            rise_sel <= pwdata[lvrx_pkg::CTRL_RISE_BIT];
            aclr <= pwdata[lvrx_pkg::CTRL_ACLR_BIT];
            roll <= roll_clamp;
        end
    end

    assign cfg.edge_rise_sel = rise_sel;
    assign cfg.align_clr = aclr;
    assign cfg.roll_limit = roll;
endmodule : lvrx_apb

// File: src/lvrx_top.sv
// lvds receive word alignment with capture edge select and bitslip
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module lvrx_top #(
    parameter bit HARD_SERDES = 1'b1,
    parameter bit DPA_MODE = 1'b0,
    parameter bit INDEP_SLIP = 1'b1,
    parameter bit OUT_REG = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [lvrx_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lvds_clk,
    input wire logic [lvrx_pkg::CH-1:0] lvds_din,
    input wire logic rx_rst,
    input wire logic align_rst,
    input wire logic [lvrx_pkg::CH-1:0] slip,
    output logic [lvrx_pkg::CH*lvrx_pkg::DESER-1:0] rx_data,
    output logic [lvrx_pkg::CH-1:0] rx_valid,
    output logic [lvrx_pkg::CH-1:0] rx_max
);
    localparam int CH = lvrx_pkg::CH;
    localparam int J = lvrx_pkg::DESER;
    localparam logic [2:0] LAST_BIT = 3'(J - 1);

    lvrx_reg_if cfg ();

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    lvrx_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cfg(cfg.regs)
    );

    // ------------------------------------------------------------
    // receiver reset
    // ------------------------------------------------------------
    logic rcv_rst_n;
    logic rx_rst_used;

    // the pll sits outside; with hard serdes the registers keep their state
    assign rx_rst_used = HARD_SERDES ? 1'b0 : rx_rst;
    assign rcv_rst_n = presetn & ~rx_rst_used;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3;
    logic [CH-1:0] din_s1;
    logic [CH-1:0] din_s2;
    logic [CH-1:0] slip_s1;
    logic [CH-1:0] slip_s2;
    logic arst_s1;
    logic arst_s2;

    always_ff @(posedge pclk or negedge rcv_rst_n) begin
        if (!rcv_rst_n) begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            lclk_s1 <= lvds_clk;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
            din_s1 <= lvds_din;
            din_s2 <= din_s1;
        end
    end

    always_ff @(posedge pclk or negedge rcv_rst_n) begin
        if (!rcv_rst_n) begin
            slip_s1 <= '0;
            slip_s2 <= '0;
            arst_s1 <= 1'b0;
            arst_s2 <= 1'b0;
        end else begin
            slip_s1 <= slip;
            slip_s2 <= slip_s1;
            arst_s1 <= align_rst;
            arst_s2 <= arst_s1;
        end
    end

    // ------------------------------------------------------------
    // capture edge selection
    // ------------------------------------------------------------
    logic edge_sel_ok;
    logic rise_sel;
    logic lclk_rise;
    logic lclk_fall;
    logic cap;
    logic align_clr;

    assign edge_sel_ok = HARD_SERDES & ~DPA_MODE;
    assign rise_sel = edge_sel_ok ? cfg.edge_rise_sel : 1'b1;
    assign lclk_rise = lclk_s2 & ~lclk_s3;
    assign lclk_fall = ~lclk_s2 & lclk_s3;
    // falling capture shifts the sample point by half a link period
    assign cap = rise_sel ? lclk_rise : lclk_fall;
    assign align_clr = arst_s2 | cfg.align_clr;

    // ------------------------------------------------------------
    // common parallel tick
    // ------------------------------------------------------------
    logic [2:0] pcnt;
    logic par_tick;

    assign par_tick = cap & (pcnt == LAST_BIT);

    always_ff @(posedge pclk or negedge rcv_rst_n) begin
        if (!rcv_rst_n) begin
            pcnt <= 3'h0;
        end else if (cap) begin
            pcnt <= pcnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // per-channel deserialiser and word alignment
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            logic [J-1:0] sh;
            logic [J-1:0] word;
            logic [J-1:0] data_q;
            logic [2:0] bcnt;
            logic pend;
            logic slip_req;
            logic blank;
            logic at_max;
            logic slip_src;
            logic word_done;
            logic valid_q;
            logic max_q;

            // shared mode drives every channel from the first slip pin
            assign slip_src = INDEP_SLIP ? slip_s2[g] : slip_s2[0];
            assign word_done = cap & ~pend & (bcnt == LAST_BIT);

            lvrx_slip u_slip (
                .clk(pclk),
                .rst_n(rcv_rst_n),
                .tick(par_tick),
                .slip_in(slip_src),
                .align_clr(align_clr),
                .roll_limit(cfg.roll_limit),
                .slip_req(slip_req),
                .blank(blank),
                .at_max(at_max)
            );

            always_ff @(posedge pclk or negedge rcv_rst_n) begin
                if (!rcv_rst_n) begin
                    sh <= '0;
                end else if (cap) begin
                    sh <= {sh[J-2:0], din_s2[g]};
                end
            end

            // a pending slip holds the bit counter for one bit time
            always_ff @(posedge pclk or negedge rcv_rst_n) begin
                if (!rcv_rst_n) begin
                    pend <= 1'b0;
                    bcnt <= 3'h0;
                end else if (align_clr) begin
                    pend <= 1'b0;
                    bcnt <= 3'h0;
                end else begin
                    pend <= slip_req | (pend & ~cap);
                    if (cap && !pend) begin
                        bcnt <= bcnt + 3'h1;
                    end
                end
            end

            always_ff @(posedge pclk or negedge rcv_rst_n) begin
                if (!rcv_rst_n) begin
                    word <= '0;
                end else if (word_done) begin
                    word <= {sh[J-2:0], din_s2[g]};
                end
            end

            always_ff @(posedge pclk or negedge rcv_rst_n) begin
                if (!rcv_rst_n) begin
                    data_q <= '0;
                    valid_q <= 1'b0;
                    max_q <= 1'b0;
                end else if (par_tick) begin
                    data_q <= word;
                    valid_q <= ~blank;
                    max_q <= at_max;
                end
            end

            if (OUT_REG) begin : g_reg
                assign rx_data[g*J +: J] = data_q;
            end else begin : g_raw
                assign rx_data[g*J +: J] = word;
            end
            assign rx_valid[g] = valid_q;
            assign rx_max[g] = max_q;
            assign cfg.word[g] = word;
        end
    endgenerate

    assign cfg.valid = rx_valid;
    assign cfg.max = rx_max;
endmodule : lvrx_top

// File: sim/lvrx_tx_model.sv
// serial transmitter model sending one repeating character per channel
`timescale 1ns/10ps
module lvrx_tx_model (
    output logic lvds_clk,
    output logic [lvrx_pkg::CH-1:0] lvds_din,
    input wire logic centre_fall,
    input wire logic [lvrx_pkg::CH*lvrx_pkg::DESER-1:0] chars
);
    int idx;
    initial begin
        lvds_clk = 1'b0;
        lvds_din = '0;
        idx = 0;
        #3.3;
        forever begin
            #40 lvds_clk = ~lvds_clk;
            // launch half a period away from the capturing edge
            if (lvds_clk == centre_fall) begin
                for (int g = 0; g < lvrx_pkg::CH; g++) begin
                    lvds_din[g] = chars[g * lvrx_pkg::DESER + 7 - idx];
                end
                idx = (idx + 1) % lvrx_pkg::DESER;
            end
        end
    end
endmodule : lvrx_tx_model

// File: sim/lvrx_top_asserts.sv
// port checks for the receive alignment top
`timescale 1ns/10ps
module lvrx_top_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [lvrx_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_rst,
    input wire logic align_rst,
    input wire logic [lvrx_pkg::CH-1:0] slip,
    input wire logic [lvrx_pkg::CH*lvrx_pkg::DESER-1:0] rx_data,
    input wire logic [lvrx_pkg::CH-1:0] rx_valid,
    input wire logic [lvrx_pkg::CH-1:0] rx_max
);
    logic v_q, m_q, armed, next_armed, mapped;
    logic [8:0] lo_cnt;
    logic [7:0] hi_cnt;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    assign mapped = paddr == lvrx_pkg::CTRL_OFS || paddr == lvrx_pkg::STAT_OFS
        || (paddr[7:4] == 4'h1 && paddr[1:0] == 2'h0);
    // armed by a valid drop, disarmed by alignment clear or a write
    assign next_armed = !align_rst && !(psel && pwrite) && !rx_valid[2]
        && (v_q || armed);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            v_q <= 1'b0;
            m_q <= 1'b0;
            armed <= 1'b0;
            lo_cnt <= 9'h0;
            hi_cnt <= 8'h0;
        end else begin
            v_q <= rx_valid[2];
            m_q <= rx_max[2];
            armed <= next_armed;
            lo_cnt <= rx_valid[2] ? 9'h0 : lo_cnt + 9'h1;
            hi_cnt <= rx_max[2] ? hi_cnt + 8'h1 : 8'h0;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence
    a_pready_after_setup: assert property (setup_s |=> answer_s)
        else $error("no answer in access cycle");
    a_pready_single: assert property (answer_s |=> !pready)
        else $error("answer held too long");
    a_unmapped_err: assert property (
        psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ro_write_err: assert property (
        psel && !penable && pwrite && paddr != lvrx_pkg::CTRL_OFS |=> pslverr)
        else $error("read-only write not refused");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read bus busy outside access");
    a_valid_blank: assert property (
        armed && !v_q && rx_valid[2] |-> lo_cnt >= 9'hb8 && lo_cnt <= 9'hc8)
        else $error("valid blank length wrong");
    a_max_one_tick: assert property (
        m_q && !rx_max[2] |-> hi_cnt >= 8'h3c && hi_cnt <= 8'h44)
        else $error("rollover flag not one word long");
    a_word_hold: assert property (
        $changed(rx_data) |=> $stable(rx_data) [*8])
        else $error("word changed between ticks");
    a_rxrst_ignored: assert property (
        rx_rst && rx_valid == 4'hf && slip == 4'h0 && !align_rst
        |=> rx_valid == 4'hf)
        else $error("receiver reset acted in hard build");
endmodule : lvrx_top_asserts

bind lvrx_top lvrx_top_asserts lvrx_top_asserts_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_rst(rx_rst),
    .align_rst(align_rst), .slip(slip), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_max(rx_max)
);

// File: sim/testbench.sv
// self-checking bench for the lvds receive word alignment block
`timescale 1ns/10ps
module testbench;
    localparam int TICK = 64;
    localparam logic [31:0] CHARS = 32'h1d4b6387;
    logic pclk = 1'b0;
    int max_at = 0;
    int t0 = 0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic lvds_clk, rx_rst, align_rst, centre_fall;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rx_data, seen;
    logic [3:0] lvds_din, slip, rx_valid, rx_max, vseen;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;

    lvrx_top lvrx_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lvds_clk(lvds_clk), .lvds_din(lvds_din), .rx_rst(rx_rst),
        .align_rst(align_rst), .slip(slip), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_max(rx_max)
    );
    lvrx_tx_model lvrx_tx_model_i (
        .lvds_clk(lvds_clk), .lvds_din(lvds_din),
        .centre_fall(centre_fall), .chars(CHARS)
    );

    always #5 pclk = ~pclk;

    // outputs sampled mid-cycle, away from the update edge
    always @(negedge pclk) begin
        seen <= rx_data;
        vseen <= rx_valid;
        if (rx_max[2])
            max_at <= cyc;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic check(input string s, input logic [31:0] x,
            input logic [31:0] y);
        checked++;
        if (y !== x) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", s, x, y);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge pclk);
    endtask : ticks

    // one apb transfer; d is write data, or expected read data
    task automatic acc(input logic [7:0] a, input logic w,
            input logic [31:0] d, input logic e);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // answer and read data are taken at the edge that sees pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        check("pready", 32'h1, {31'h0, pready});
        check("pslverr", {31'h0, e}, {31'h0, pslverr});
        if (!w)
            check("prdata", d, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : acc

    task automatic slip_pulse(input int g, input int hold);
        logic [31:0] old, m;
        logic [7:0] o, n;
        logic ok;
        old = seen;
        m = 32'hff << (8 * g);
        o = old[8*g+:8];
        slip[g] <= 1'b1;
        ticks(2);
        check("valid blank", 32'h0, {31'h0, vseen[g]});
        ticks(hold - 2);
        slip[g] <= 1'b0;
        ticks(5);
        n = seen[8*g+:8];
        ok = n === {o[6:0], o[7]} || n === {o[0], o[7:1]};
        check("valid back", 32'hf, {28'h0, vseen});
        check("other words", old & ~m, seen & ~m);
        check("one bit slip", 32'h1, {31'h0, ok});
    endtask : slip_pulse

    task automatic align(input int g);
        int k;
        k = 0;
        while (seen[8*g+:8] !== CHARS[8*g+:8] && k < 8) begin
            slip_pulse(g, 2);
            k++;
        end
        check("aligned", {24'h0, CHARS[8*g+:8]},
            {24'h0, seen[8*g+:8]});
    endtask : align

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rx_rst = 1'b0;
        align_rst = 1'b0;
        slip = 4'h0;
        centre_fall = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(lvrx_pkg::CTRL_OFS, 1'b0, 32'h0801, 1'b0);
        acc(8'h08, 1'b0, 32'h0, 1'b1);
        acc(lvrx_pkg::STAT_OFS, 1'b1, 32'h1, 1'b1);
        acc(lvrx_pkg::CTRL_OFS, 1'b1, 32'h0c01, 1'b0);
        acc(lvrx_pkg::CTRL_OFS, 1'b0, 32'h0b01, 1'b0);
        acc(lvrx_pkg::CTRL_OFS, 1'b1, 32'h0001, 1'b0);
        acc(lvrx_pkg::CTRL_OFS, 1'b0, 32'h0101, 1'b0);
        acc(lvrx_pkg::CTRL_OFS, 1'b1, 32'h0801, 1'b0);
        ticks(6);
        for (int g = 0; g < 4; g++) begin
            align(g);
        end
        acc(lvrx_pkg::STAT_OFS, 1'b0, 32'h000f, 1'b0);
        slip_pulse(1, 20);
        align(1);
        acc(lvrx_pkg::CTRL_OFS, 1'b1, 32'h0301, 1'b0);
        align_rst <= 1'b1;
        ticks(2);
        align_rst <= 1'b0;
        ticks(3);
        t0 = cyc;
        slip_pulse(2, 2);
        slip_pulse(2, 2);
        check("early max", 32'h0, {31'h0, max_at > t0});
        slip_pulse(2, 2);
        check("max", 32'h1, {31'h0, max_at > t0});
        rx_rst <= 1'b1;
        ticks(1);
        rx_rst <= 1'b0;
        ticks(1);
        check("valid", 32'hf, {28'h0, vseen});
        centre_fall <= 1'b1;
        acc(lvrx_pkg::CTRL_OFS, 1'b1, 32'h0300, 1'b0);
        ticks(4);
        align(0);
        acc(lvrx_pkg::DATA_OFS, 1'b0, {24'h0, CHARS[7:0]}, 1'b0);
        close_out();
    end
endmodule : testbench
